// file: rtl/dpio_top.sv
// Dual general-purpose I/O ports with pin-change flag, AXI4-Lite slave.
// Pins are synchronous to aclk; the pad ring resolves the wire levels.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Five-pin first port, direction and latch
// - First port: 1 input, 0 drives latch
// - First port resets to inputs, latch zero
// - Reads return pins, writes update latch
// - Writes are read-modify-write from pin levels
// - Shared timer pin output is open drain
// - Eight-pin second port, direction and latch
// - Second port: 1 input, 0 drives latch
// - Global active-low pull-up bit, option bit 7
// - Pull-up off when pin is output
// - Pull-ups disabled after reset
// - Upper four inputs only watched for change
// - Compare against snapshot from last second-port read or write
// - Mismatches ORed into flag, control bit 0
// - Pin change can wake from sleep
// - Port access refreshes snapshot, ends mismatch
// - Persisting mismatch keeps setting the flag
// - Hardware sets flag, only software clears
// - Flag sets regardless of enables
// - Enable bit 3 gates interrupt request
module dpio_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [4:0] first_port_in,
   output logic [4:0] first_port_out,
   output logic [4:0] first_port_oe,
   input wire logic [7:0] second_port_in,
   output logic [7:0] second_port_out,
   output logic [7:0] second_port_oe,
   output logic [7:0] second_port_pullup,
   output logic shared_timer_clock_pin,
   output logic pin_change_irq,
   output logic pin_change_wake
);

   dpio_pkg::dpio_state_s s_r;
   dpio_pkg::dpio_state_s s_nxt;
   logic [3:0] mismatch;

   // ****************************************************
   // Change detection on the upper second-port inputs
   // ****************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_watch
         assign mismatch[gi] = s_r.dir_b[dpio_pkg::WATCH_LO + gi] &
            (second_port_in[dpio_pkg::WATCH_LO + gi] != s_r.snap[gi]);
      end
   endgenerate

   always_comb begin
      logic wr_fire;
      logic rd_fire;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [4:0] ra;
      logic hit_b;
      wr_fire = 1'b0;
      rd_fire = 1'b0;
      wd = 8'h00;
      rd = 8'h00;
      ra = 5'h00;
      hit_b = 1'b0;
      s_nxt = s_r;

      // ****************************************************
      // Write path: address and data in either order
      // ****************************************************
      if (s_axi_awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr[4:0];
         s_nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
         s_nxt.wready = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         wr_fire = 1'b1;
         wd = s_r.w_data[7:0];
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = dpio_pkg::RESP_OKAY;
         if (s_r.w_strb[0]) begin
            if (s_r.aw_addr == dpio_pkg::ADDR_FIRST_PORT_VALUE) begin
               // Latch takes the pins merged with the written bits
               s_nxt.lat_a = (first_port_in & s_r.dir_a) |
                  (wd[4:0] & ~s_r.dir_a);
            end else if (s_r.aw_addr ==
                  dpio_pkg::ADDR_FIRST_PORT_DIRECTION) begin
               s_nxt.dir_a = wd[4:0];
            end else if (s_r.aw_addr ==
                  dpio_pkg::ADDR_SECOND_PORT_VALUE) begin
               s_nxt.lat_b = (second_port_in & s_r.dir_b) |
                  (wd & ~s_r.dir_b);
               hit_b = 1'b1;
            end else if (s_r.aw_addr ==
                  dpio_pkg::ADDR_SECOND_PORT_DIRECTION) begin
               s_nxt.dir_b = wd;
            end else if (s_r.aw_addr == dpio_pkg::ADDR_OPTION) begin
               s_nxt.option = wd;
            end else if (s_r.aw_addr ==
                  dpio_pkg::ADDR_INTERRUPT_CONTROL) begin
               s_nxt.intctl = wd;
            end else begin
               s_nxt.bresp = dpio_pkg::RESP_SLVERR;
            end
         end else if (s_r.aw_addr > dpio_pkg::ADDR_INTERRUPT_CONTROL ||
               s_r.aw_addr[1:0] != 2'h0) begin
            s_nxt.bresp = dpio_pkg::RESP_SLVERR;
         end
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end

      // ****************************************************
      // Read path: pins read live
      // ****************************************************
      if (s_axi_arvalid && s_r.arready) begin
         rd_fire = 1'b1;
         ra = s_axi_araddr[4:0];
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = dpio_pkg::RESP_OKAY;
         if (ra == dpio_pkg::ADDR_FIRST_PORT_VALUE) begin
            rd = {3'h0, first_port_in};
         end else if (ra == dpio_pkg::ADDR_FIRST_PORT_DIRECTION) begin
            rd = {3'h0, s_r.dir_a};
         end else if (ra == dpio_pkg::ADDR_SECOND_PORT_VALUE) begin
            rd = second_port_in;
            hit_b = 1'b1;
         end else if (ra == dpio_pkg::ADDR_SECOND_PORT_DIRECTION) begin
            rd = s_r.dir_b;
         end else if (ra == dpio_pkg::ADDR_OPTION) begin
            rd = s_r.option;
         end else if (ra == dpio_pkg::ADDR_INTERRUPT_CONTROL) begin
            rd = s_r.intctl;
         end else begin
            s_nxt.rresp = dpio_pkg::RESP_SLVERR;
         end
         s_nxt.rdata = {24'h000000, rd};
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end

      // ****************************************************
      // Snapshot refresh and flag set (set beats clear)
      // ****************************************************
      if (hit_b) begin
         s_nxt.snap = second_port_in[7:4];
      end
      if (|mismatch) begin
         s_nxt.intctl[dpio_pkg::PIN_CHANGE_FLAG_BIT] = 1'b1;
      end

      // ****************************************************
      // Registered pad drive and requests
      // ****************************************************
      s_nxt.a_oe = ~s_nxt.dir_a;
      s_nxt.a_oe[dpio_pkg::SHARED_PIN_BIT] =
         ~s_nxt.dir_a[dpio_pkg::SHARED_PIN_BIT] &
         ~s_nxt.lat_a[dpio_pkg::SHARED_PIN_BIT];
      s_nxt.a_out = s_nxt.lat_a;
      s_nxt.a_out[dpio_pkg::SHARED_PIN_BIT] = 1'b0;
      s_nxt.b_oe = ~s_nxt.dir_b;
      s_nxt.b_out = s_nxt.lat_b;
      s_nxt.b_pu = {8{~s_nxt.option[dpio_pkg::PULLUP_EN_N_BIT]}} &
         s_nxt.dir_b;
      s_nxt.irq = s_nxt.intctl[dpio_pkg::PIN_CHANGE_FLAG_BIT] &
         s_nxt.intctl[dpio_pkg::PIN_CHANGE_EN_BIT] &
         s_nxt.intctl[dpio_pkg::GLOBAL_IRQ_EN_BIT];
      s_nxt.wake = s_nxt.intctl[dpio_pkg::PIN_CHANGE_FLAG_BIT] &
         s_nxt.intctl[dpio_pkg::PIN_CHANGE_EN_BIT];
      if (wr_fire || rd_fire) begin
         s_nxt.w_data = s_nxt.w_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.dir_a <= dpio_pkg::FIRST_DIR_RST;
         s_r.dir_b <= dpio_pkg::SECOND_DIR_RST;
         s_r.lat_a <= dpio_pkg::FIRST_LATCH_RST;
         s_r.lat_b <= dpio_pkg::SECOND_LATCH_RST;
         s_r.option <= dpio_pkg::OPTION_RST;
         s_r.intctl <= dpio_pkg::INTCTL_RST;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign first_port_out = s_r.a_out;
   assign first_port_oe = s_r.a_oe;
   assign second_port_out = s_r.b_out;
   assign second_port_oe = s_r.b_oe;
   assign second_port_pullup = s_r.b_pu;
   assign shared_timer_clock_pin = s_r.a_oe[dpio_pkg::SHARED_PIN_BIT];
   assign pin_change_irq = s_r.irq;
   assign pin_change_wake = s_r.wake;

endmodule : dpio_top
`default_nettype wire

// file: pkg/dpio_pkg.sv
// Package for the dual I/O port block with pin-change detection.
// Assumes an AXI4-Lite register slave with 32-bit data.
package dpio_pkg;

   // ****************************************************
   // Register map (byte addresses)
   // ****************************************************
   localparam logic [4:0] ADDR_FIRST_PORT_VALUE = 5'h00;
   localparam logic [4:0] ADDR_FIRST_PORT_DIRECTION = 5'h04;
   localparam logic [4:0] ADDR_SECOND_PORT_VALUE = 5'h08;
   localparam logic [4:0] ADDR_SECOND_PORT_DIRECTION = 5'h0C;
   localparam logic [4:0] ADDR_OPTION = 5'h10;
   localparam logic [4:0] ADDR_INTERRUPT_CONTROL = 5'h14;

   // ****************************************************
   // Field positions and widths
   // ****************************************************
   localparam int FIRST_W = 5;
   localparam int SECOND_W = 8;
   localparam int SHARED_PIN_BIT = 4;
   localparam int PULLUP_EN_N_BIT = 7;
   localparam int PIN_CHANGE_FLAG_BIT = 0;
   localparam int PIN_CHANGE_EN_BIT = 3;
   localparam int GLOBAL_IRQ_EN_BIT = 7;
   localparam int WATCH_LO = 4;

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [4:0] FIRST_DIR_RST = 5'h1F;
   localparam logic [7:0] SECOND_DIR_RST = 8'hFF;
   localparam logic [4:0] FIRST_LATCH_RST = 5'h00;
   localparam logic [7:0] SECOND_LATCH_RST = 8'h00;
   localparam logic [7:0] OPTION_RST = 8'hFF;
   localparam logic [7:0] INTCTL_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [4:0] lat_a;
      logic [4:0] dir_a;
      logic [7:0] lat_b;
      logic [7:0] dir_b;
      logic [7:0] option;
      logic [7:0] intctl;
      logic [3:0] snap;
      logic aw_got;
      logic [4:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [4:0] a_out;
      logic [4:0] a_oe;
      logic [7:0] b_out;
      logic [7:0] b_oe;
      logic [7:0] b_pu;
      logic irq;
      logic wake;
   } dpio_state_s;

endpackage : dpio_pkg

// file: verif/dpio_pins_model.sv
// Outside circuitry: drivers on both ports, float and pull-ups on the second port only.
// Assumes an enabled device driver wins over the outside one.
`timescale 1ns/100ps
`default_nettype none
module dpio_pins_model (
   input wire logic aclk,
   input wire logic [4:0] first_port_out,
   input wire logic [4:0] first_port_oe,
   input wire logic [7:0] second_port_out,
   input wire logic [7:0] second_port_oe,
   input wire logic [7:0] second_port_pullup,
   input wire logic [4:0] a_ext,
   input wire logic [7:0] b_ext,
   input wire logic [7:0] b_ext_en,
   output logic [4:0] first_port_in,
   output logic [7:0] second_port_in
);
   logic fl = 1'h0;
   // Undriven line wanders each cycle
   always @(posedge aclk) fl <= ~fl;
   assign first_port_in = (first_port_oe & first_port_out) |
      (~first_port_oe & a_ext);
   assign second_port_in = (second_port_oe & second_port_out) |
      (~second_port_oe & ((b_ext_en & b_ext) |
      (~b_ext_en & (second_port_pullup | {8{fl}}))));
endmodule : dpio_pins_model
`default_nettype wire

// file: verif/dpio_top_assertions.sv
// Port-level properties of the dual port block.
// Assumes binding into dpio_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module dpio_top_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [4:0] first_port_out,
   input wire logic [4:0] first_port_oe,
   input wire logic [7:0] second_port_oe,
   input wire logic [7:0] second_port_pullup,
   input wire logic shared_timer_clock_pin,
   input wire logic pin_change_irq,
   input wire logic pin_change_wake
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_OPEN_DRAIN: assert property (first_port_out[4] == 1'h0)
      else $error("shared pin driven high");
   AST_SHARED_PIN: assert property (
      shared_timer_clock_pin == first_port_oe[4])
      else $error("shared pin pull-low differs from enable");
   AST_PULLUP_OUT: assert property (
      (second_port_pullup & second_port_oe) == 8'h00)
      else $error("pull-up on a driven pin");
   AST_RESET_IDLE: assert property (disable iff (1'h0)
      !aresetn |=> first_port_oe == 5'h00 && second_port_oe == 8'h00
      && second_port_pullup == 8'h00)
      else $error("drivers or pull-ups on after reset");
   AST_IRQ_GATED: assert property (pin_change_irq |-> pin_change_wake)
      else $error("request without flag and enable");
   AST_FLAG_STICKY: assert property ($fell(pin_change_wake) |->
      $past(s_axi_bvalid) or ##[0:1] s_axi_bvalid)
      else $error("flag cleared without a write");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered");
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_wvalid
      && s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   cover property ($rose(pin_change_irq));
   cover property ($fell(pin_change_wake));
   cover property (second_port_pullup != 8'h00);
endmodule : dpio_top_assertions
bind dpio_top dpio_top_assertions u_chk (.*);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the dual port block, AXI4-Lite master.
// Assumes dpio_top, dpio_pins_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, r;
   logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, s = 32'h1DEC80E8;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] first_port_in, first_port_out, first_port_oe;
   logic [4:0] a_ext = 5'h00, la = 5'h00, da = 5'h1F;
   logic [7:0] second_port_in, second_port_out, second_port_oe;
   logic [7:0] second_port_pullup, b_ext = 8'h00, b_ext_en = 8'hFF;
   logic [7:0] lb = 8'h00, db = 8'hFF, op = 8'hFF;
   logic shared_timer_clock_pin, pin_change_irq, pin_change_wake;
   int n_errors = 0, checks = 0, k;
   always #10 aclk = ~aclk;
   dpio_top dut (.*);
   dpio_pins_model pins (.*);
   function logic [31:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function logic [7:0] pa();
      return 8'((da & a_ext) | (~da & la & (a_ext | 5'h0F)));
   endfunction : pa
   function logic [7:0] pb();
      return (db & b_ext) | (~db & lb);
   endfunction : pb
   task results();
      if (n_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e);
      int c;
      s_axi_awaddr <= 32'(a);
      s_axi_wdata <= 32'(d);
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      c = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         c++;
      end while (s_axi_bvalid !== 1'h1 && c < 20);
      s_axi_bready <= 1'h0;
      if (c == 20) begin n_errors++; results(); end
      chk("bresp", 8'(e), 8'(s_axi_bresp));
      @(posedge aclk);
   endtask : wr
   task rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] p);
      int c;
      s_axi_araddr <= 32'(a);
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      c = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         c++;
      end while (s_axi_rvalid !== 1'h1 && c < 20);
      s_axi_rready <= 1'h0;
      if (c == 20) begin n_errors++; results(); end
      chk("rdata", e, s_axi_rdata[7:0]);
      chk("rresp", 8'(p), 8'(s_axi_rresp));
      @(posedge aclk);
   endtask : rd
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk("oe", 8'h00, 8'(first_port_oe) | second_port_oe);
      chk("pu", 8'h00, second_port_pullup);
      rd(5'h00, 8'h00, 2'h0);
      rd(5'h04, 8'h1F, 2'h0);
      rd(5'h0C, 8'hFF, 2'h0);
      rd(5'h10, 8'hFF, 2'h0);
      for (k = 0; k < 40; k++) begin
         r = xs();
         wr(5'h04, r[7:0], 2'h0);
         da = r[4:0];
         wr(5'h0C, r[15:8], 2'h0);
         db = r[15:8];
         wr(5'h10, r[23:16], 2'h0);
         op = r[23:16];
         a_ext <= r[28:24];
         b_ext <= r[31:24] ^ r[7:0];
         r = xs();
         wr(5'h00, r[7:0], 2'h0);
         la = (5'(pa()) & da) | (r[4:0] & ~da);
         wr(5'h08, r[15:8], 2'h0);
         lb = (pb() & db) | (r[15:8] & ~db);
         chk("oe_a", 8'({~da[4] & ~la[4], ~da[3:0]}), 8'(first_port_oe));
         chk("out_a", 8'(la & 5'h0F), 8'(first_port_out));
         chk("oe_b", ~db, second_port_oe);
         chk("out_b", lb, second_port_out);
         chk("pu_b", {8{~op[7]}} & db, second_port_pullup);
         rd(5'h00, pa(), 2'h0);
         rd(5'h04, 8'(da), 2'h0);
         rd(5'h08, pb(), 2'h0);
      end
      wr(5'h0C, 8'hFF, 2'h0);
      db = 8'hFF;
      rd(5'h08, pb(), 2'h0);
      wr(5'h14, 8'h00, 2'h0);
      b_ext <= b_ext ^ 8'h0F;
      rd(5'h14, 8'h00, 2'h0);
      b_ext <= b_ext ^ 8'h20;
      @(posedge aclk);
      rd(5'h14, 8'h01, 2'h0);
      wr(5'h14, 8'h88, 2'h0);
      rd(5'h14, 8'h89, 2'h0);
      chk("irq", 8'h01, 8'(pin_change_irq));
      chk("wake", 8'h01, 8'(pin_change_wake));
      rd(5'h08, pb(), 2'h0);
      wr(5'h14, 8'h88, 2'h0);
      rd(5'h14, 8'h88, 2'h0);
      chk("wake", 8'h00, 8'(pin_change_wake));
      wr(5'h10, 8'h7F, 2'h0);
      b_ext_en <= 8'h00;
      rd(5'h08, 8'hFF, 2'h0);
      b_ext_en <= 8'hFF;
      rd(5'h18, 8'h00, 2'h2);
      wr(5'h1C, 8'h00, 2'h2);
      s_axi_wstrb <= 4'hE;
      wr(5'h04, 8'h00, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(5'h04, 8'(da), 2'h0);
      results();
   end
endmodule : testbench
`default_nettype wire
